// ==== core/stepper_image_coupler.sv ====
`timescale 1ns/1ps
module stepper_image_coupler #(
	parameter int CYCLE_DIV = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device side
	stepper_image_if.coupler link,
	// aligned view of input image
	output logic [7:0] aligned_in [0:5]
);
	initial begin
		if (CYCLE_DIV < 2) $error("cycle divider must be at least 2");
	end
	logic [15:0] div_r;
	logic [7:0] ctrl_r;
	logic [15:0] dout_r;
	logic [15:0] ext_r;
	logic align_r;
	logic acc;
	// ----------------------------------------
	// exchange cycle divider
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 16'h0000;
		end else if (div_r == 16'(CYCLE_DIV - 1)) begin
			div_r <= 16'h0000;
		end else begin
			div_r <= div_r + 16'h0001;
		end
	end
	assign link.cycle = (div_r == 16'(CYCLE_DIV - 1));
	// ----------------------------------------
	// apb registers
	// ----------------------------------------
	assign acc = psel && penable;
	assign pready = 1'b1;
	always_comb begin
		pslverr = acc && (paddr > stepper_image_pkg::APB_RDATA);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= stepper_image_pkg::RESET_BYTE;
			dout_r <= stepper_image_pkg::RESET_WORD;
			ext_r <= stepper_image_pkg::RESET_WORD;
			align_r <= 1'b0;
		end else if (acc && pwrite) begin
			case (paddr)
				stepper_image_pkg::APB_CTRL: align_r <= pwdata[0];
				stepper_image_pkg::APB_CMD: ctrl_r <= pwdata[7:0];
				stepper_image_pkg::APB_DATA_OUT: dout_r <= pwdata[15:0];
				stepper_image_pkg::APB_EXT_OUT: ext_r <= pwdata[15:0];
				default: ctrl_r <= ctrl_r;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				stepper_image_pkg::APB_CTRL: prdata <= {31'h0, align_r};
				stepper_image_pkg::APB_CMD: prdata <= {24'h0, ctrl_r};
				stepper_image_pkg::APB_DATA_OUT: prdata <= {16'h0, dout_r};
				stepper_image_pkg::APB_EXT_OUT: prdata <= {16'h0, ext_r};
				stepper_image_pkg::APB_STATUS: prdata <= {24'h0, link.in_image[0]};
				stepper_image_pkg::APB_DATA_IN, stepper_image_pkg::APB_RDATA:
					prdata <= {16'h0, link.in_image[2], link.in_image[1]};
				stepper_image_pkg::APB_EXT_IN: prdata <= {16'h0, link.in_image[4], link.in_image[3]};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
	// ----------------------------------------
	// output image and aligned view
	// ----------------------------------------
	assign link.out_image[0] = ctrl_r;
	assign link.out_image[1] = dout_r[7:0];
	assign link.out_image[2] = dout_r[15:8];
	assign link.out_image[3] = ext_r[7:0];
	assign link.out_image[4] = ext_r[15:8];
	always_comb begin
		aligned_in[0] = link.in_image[0];
		aligned_in[1] = 8'h00;
		aligned_in[2] = link.in_image[1];
		aligned_in[3] = link.in_image[2];
		aligned_in[4] = link.in_image[3];
		aligned_in[5] = link.in_image[4];
		if (!align_r) begin
			aligned_in[1] = link.in_image[1];
			aligned_in[2] = link.in_image[2];
			aligned_in[3] = link.in_image[3];
			aligned_in[4] = link.in_image[4];
			aligned_in[5] = 8'h00;
		end
	end
endmodule

// ==== core/stepper_image_device.sv ====
`timescale 1ns/1ps
// Overview of operation
// - always present full image with status bytes
// - five input and five output bytes
// - byte0 status/control, 1-2 data, 3-4 extended
// - aligned coupler puts words at bytes 2,4
// - input word carries low actual position
// - full position readable via registers 0,1
// - direct velocity: sign plus 15-bit magnitude
// - ramp velocity uses bits 4 to 15
// - tracking: set position sign plus 15 bits
// - manual velocity uses bits 4 to 15
// - manual velocity only while start bit low
// - controller writes target registers before start
// - control bit7 low: process data, echoed
// - start bit 1 starts, 0 stops command
// - bit7 set: register access, rw, number
module stepper_image_device #(
	parameter int POS_WIDTH = 32
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// coupler side
	stepper_image_if.device link,
	// motion side
	input wire stepper_image_pkg::mode_e mode,
	input wire logic [POS_WIDTH-1:0] actual_position,
	input wire logic motion_idle,
	input wire logic [15:0] ext_status,
	output logic motor_enable,
	output logic motion_start_bit,
	output logic signed [15:0] velocity_cmd,
	output logic velocity_valid,
	output logic signed [15:0] set_position,
	output logic [31:0] target_position,
	output logic [15:0] ext_control
);
	initial begin
		if (POS_WIDTH != 32) $error("position width must be 32");
		if (stepper_image_pkg::IMAGE_BYTES != 5) $error("image must hold five bytes");
		if (stepper_image_pkg::OFS_EXT + 2 > stepper_image_pkg::IMAGE_BYTES)
			$error("extended word outside image");
		if (stepper_image_pkg::MAG_LSB_RAMP != 4) $error("ramp field must start at bit 4");
	end
	logic [7:0] ctrl_r;
	logic [15:0] dout_r;
	logic [15:0] tgt_lo_r;
	logic [15:0] tgt_hi_r;
	logic [15:0] rd_word;
	logic reg_mode;
	logic [5:0] reg_num;
	logic [7:0] sts;
	logic signed [15:0] vel_nxt;
	logic vel_take;
	logic [15:0] data_in_word;
	logic [7:0] img_nxt [0:4];
	// ----------------------------------------
	// output image capture
	// ----------------------------------------
	// all three fields are taken on one strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= stepper_image_pkg::RESET_BYTE;
			dout_r <= stepper_image_pkg::RESET_WORD;
			ext_control <= stepper_image_pkg::RESET_WORD;
		end else if (link.cycle) begin
			ctrl_r <= link.out_image[stepper_image_pkg::OFS_CTRL];
			dout_r <= {link.out_image[stepper_image_pkg::OFS_DATA+1],
				link.out_image[stepper_image_pkg::OFS_DATA]};
			ext_control <= {link.out_image[stepper_image_pkg::OFS_EXT+1],
				link.out_image[stepper_image_pkg::OFS_EXT]};
		end
	end
	assign reg_mode = ctrl_r[stepper_image_pkg::BIT_REG_SELECT];
	assign reg_num = ctrl_r[stepper_image_pkg::REG_NUM_MSB:0];
	// ----------------------------------------
	// register channel writes
	// ----------------------------------------
	// a held write lands again each clock, harmlessly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tgt_lo_r <= stepper_image_pkg::RESET_WORD;
			tgt_hi_r <= stepper_image_pkg::RESET_WORD;
		end else if (reg_mode && ctrl_r[stepper_image_pkg::BIT_REG_WRITE]) begin
			if (reg_num == stepper_image_pkg::REG_TGT_POS_LO) begin
				tgt_lo_r <= dout_r;
			end
			if (reg_num == stepper_image_pkg::REG_TGT_POS_HI) begin
				tgt_hi_r <= dout_r;
			end
		end
	end
	assign target_position = {tgt_hi_r, tgt_lo_r};
	// ----------------------------------------
	// register channel read
	// ----------------------------------------
	// unknown register numbers read as zero
	always_comb begin
		case (reg_num)
			stepper_image_pkg::REG_ACT_POS_LO: rd_word = actual_position[15:0];
			stepper_image_pkg::REG_ACT_POS_HI: rd_word = actual_position[31:16];
			stepper_image_pkg::REG_TGT_POS_LO: rd_word = tgt_lo_r;
			stepper_image_pkg::REG_TGT_POS_HI: rd_word = tgt_hi_r;
			default: rd_word = stepper_image_pkg::RESET_WORD;
		endcase
	end
	// ----------------------------------------
	// enable and motion start
	// ----------------------------------------
	// both held while the register channel owns the data words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motor_enable <= 1'b0;
		end else if (!reg_mode) begin
			motor_enable <= ctrl_r[stepper_image_pkg::BIT_ENABLE];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motion_start_bit <= 1'b0;
		end else if (!reg_mode) begin
			motion_start_bit <= (mode == stepper_image_pkg::MODE_TRAVEL) &&
				ctrl_r[stepper_image_pkg::BIT_MOTION_START];
		end
	end
	// ----------------------------------------
	// velocity decode of the output word
	// ----------------------------------------
	always_comb begin
		vel_nxt = velocity_cmd;
		vel_take = 1'b0;
		case (mode)
			stepper_image_pkg::MODE_VEL_DIRECT: begin
				vel_nxt = dout_r;
				vel_take = 1'b1;
			end
			stepper_image_pkg::MODE_VEL_RAMP: begin
				vel_nxt = {dout_r[15:stepper_image_pkg::MAG_LSB_RAMP], 4'h0};
				vel_take = 1'b1;
			end
			stepper_image_pkg::MODE_TRAVEL: begin
				// a running motion command owns the axis
				if (!ctrl_r[stepper_image_pkg::BIT_MOTION_START]) begin
					vel_nxt = {dout_r[15:stepper_image_pkg::MAG_LSB_RAMP], 4'h0};
					vel_take = 1'b1;
				end
			end
			default: begin
				vel_nxt = velocity_cmd;
				vel_take = 1'b0;
			end
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			velocity_cmd <= stepper_image_pkg::RESET_WORD;
			velocity_valid <= 1'b0;
		end else if (!reg_mode) begin
			velocity_cmd <= vel_nxt;
			velocity_valid <= vel_take;
		end
	end
	// set position follows the word only in tracking mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			set_position <= stepper_image_pkg::RESET_WORD;
		end else if (!reg_mode && mode == stepper_image_pkg::MODE_POS_TRACK) begin
			set_position <= dout_r;
		end
	end
	// ----------------------------------------
	// input image
	// ----------------------------------------
	// status echoes bit7 and, in register mode, the register number of the previous exchange's control byte
	always_comb begin
		sts = stepper_image_pkg::RESET_BYTE;
		sts[stepper_image_pkg::BIT_REG_SELECT] = reg_mode;
		sts[stepper_image_pkg::BIT_IDLE] = motion_idle;
		sts[stepper_image_pkg::BIT_READY] = motor_enable;
		if (reg_mode) begin
			sts[stepper_image_pkg::REG_NUM_MSB:0] = reg_num;
		end
	end
	// register channel answer replaces the position word
	always_comb begin
		data_in_word = actual_position[15:0];
		if (reg_mode) begin
			data_in_word = rd_word;
		end
	end
	always_comb begin
		img_nxt[stepper_image_pkg::OFS_CTRL] = sts;
		img_nxt[stepper_image_pkg::OFS_DATA] = data_in_word[7:0];
		img_nxt[stepper_image_pkg::OFS_DATA+1] = data_in_word[15:8];
		img_nxt[stepper_image_pkg::OFS_EXT] = ext_status[7:0];
		img_nxt[stepper_image_pkg::OFS_EXT+1] = ext_status[15:8];
	end
	// every byte loads on the same strobe, so no word is ever torn
	for (genvar g = 0; g < stepper_image_pkg::IMAGE_BYTES; g++) begin : g_in_byte
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				link.in_image[g] <= stepper_image_pkg::RESET_BYTE;
			end else if (link.cycle) begin
				link.in_image[g] <= img_nxt[g];
			end
		end
	end
endmodule

// ==== core/stepper_image_if.sv ====
`timescale 1ns/1ps
interface stepper_image_if;
	logic cycle;
	logic [7:0] out_image [0:4];
	logic [7:0] in_image [0:4];
	modport device (
		input cycle,
		input out_image,
		output in_image
	);
	modport coupler (
		output cycle,
		output out_image,
		input in_image
	);
endinterface

// ==== core/stepper_image_pkg.sv ====
package stepper_image_pkg;
	// ----------------------------------------
	// image layout
	// ----------------------------------------
	localparam int IMAGE_BYTES = 5;
	localparam int OFS_CTRL = 0;
	localparam int OFS_DATA = 1;
	localparam int OFS_EXT = 3;
	localparam int OFS_DATA_ALIGNED = 2;
	localparam int OFS_EXT_ALIGNED = 4;
	// ----------------------------------------
	// control and status byte fields
	// ----------------------------------------
	localparam int BIT_REG_SELECT = 7;
	localparam int BIT_REG_WRITE = 6;
	localparam int BIT_MOTION_START = 2;
	localparam int BIT_ENABLE = 0;
	localparam int BIT_READY = 0;
	localparam int BIT_IDLE = 4;
	localparam int REG_NUM_MSB = 5;
	localparam int MAG_LSB_RAMP = 4;
	// ----------------------------------------
	// internal register numbers
	// ----------------------------------------
	localparam logic [5:0] REG_ACT_POS_LO = 6'h00;
	localparam logic [5:0] REG_ACT_POS_HI = 6'h01;
	localparam logic [5:0] REG_TGT_POS_LO = 6'h02;
	localparam logic [5:0] REG_TGT_POS_HI = 6'h03;
	// ----------------------------------------
	// controller registers on apb
	// ----------------------------------------
	localparam logic [7:0] APB_CTRL = 8'h00;
	localparam logic [7:0] APB_CMD = 8'h04;
	localparam logic [7:0] APB_DATA_OUT = 8'h08;
	localparam logic [7:0] APB_EXT_OUT = 8'h0C;
	localparam logic [7:0] APB_STATUS = 8'h10;
	localparam logic [7:0] APB_DATA_IN = 8'h14;
	localparam logic [7:0] APB_EXT_IN = 8'h18;
	localparam logic [7:0] APB_RDATA = 8'h1C;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// ----------------------------------------
	// operating modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_VEL_DIRECT,
		MODE_VEL_RAMP,
		MODE_POS_TRACK,
		MODE_TRAVEL
	} mode_e;
endpackage

// ==== tb/stepper_image_props.sv ====
`timescale 1ns/1ps
module stepper_image_props #(
	parameter int CYCLE_DIV = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link
	input wire logic cycle,
	input wire logic [7:0] out_image [0:4],
	input wire logic [7:0] in_image [0:4]
);
	logic [39:0] in_w;
	logic [7:0] ctl;
	logic [7:0] sts;
	int cnt;
	logic seen;
	logic [7:0] ctl_q;
	assign in_w = {in_image[0], in_image[1], in_image[2], in_image[3], in_image[4]};
	assign ctl = out_image[0];
	assign sts = in_image[0];
	// ----------------------------------------
	// clocks since last exchange
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
		end else if (cycle) begin
			cnt <= 0;
		end else if (cnt < CYCLE_DIV) begin
			cnt <= cnt + 1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen <= 1'b0;
		end else if (cycle) begin
			seen <= 1'b1;
		end
	end
	// control byte the device acts on until the next exchange
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= 8'h00;
		end else if (cycle) begin
			ctl_q <= ctl;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	AST_IN_HOLD: assert property (!cycle |=> $stable(in_w))
		else $error("input image moved off cycle");
	AST_CYCLE_PULSE: assert property (cycle |=> !cycle)
		else $error("cycle strobe too long");
	AST_CYCLE_GAP: assert property (cycle && seen |-> cnt == CYCLE_DIV - 1)
		else $error("cycle spacing wrong");
	AST_CYCLE_LIVE: assert property (seen |-> cnt < CYCLE_DIV)
		else $error("cycle strobe missing");
	AST_RESET_CLEAR: assert property ($rose(presetn) |-> in_w == 40'h0)
		else $error("input image not cleared");
	AST_PROC_ACK: assert property (cycle && !ctl_q[7] |=> !sts[7])
		else $error("process mode not acknowledged");
	AST_REG_ACK: assert property (cycle && ctl_q[7] |=> sts[7] && sts[5:0] == $past(ctl_q[5:0]))
		else $error("register access not echoed");
	AST_REG_NUM_HOLD: assert property ((cycle && ctl[7]) ##1 (!cycle)[*2] |-> $stable(sts))
		else $error("register echo not held");
	cover property (cycle && ctl[7] && ctl[6]);
	cover property (cycle && ctl[7] && !ctl[6]);
	cover property (cycle && !ctl[7] && ctl[2]);
endmodule

// ==== tb/stepper_process_image_tb_top.sv ====
`timescale 1ns/1ps
module stepper_process_image_tb_top;
	localparam int CDIV = 4;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, pos;
	logic [7:0] aligned_in [0:5];
	stepper_image_pkg::mode_e mode;
	logic idle, motor_enable, motion_start_bit, velocity_valid;
	logic [15:0] ext_st, ext_control;
	logic signed [15:0] velocity_cmd, set_position;
	logic [31:0] target_position;
	int error_cnt = 0;
	int n_checks = 0;
	int ticks = 0;
	stepper_image_if link();
	stepper_image_device u_stepper_image_device (.pclk(pclk), .presetn(presetn),
		.link(link), .mode(mode), .actual_position(pos), .motion_idle(idle),
		.ext_status(ext_st), .motor_enable(motor_enable), .motion_start_bit(motion_start_bit),
		.velocity_cmd(velocity_cmd), .velocity_valid(velocity_valid),
		.set_position(set_position), .target_position(target_position),
		.ext_control(ext_control));
	stepper_image_coupler #(.CYCLE_DIV(CDIV)) u_stepper_image_coupler (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(link), .aligned_in(aligned_in));
	stepper_image_props #(.CYCLE_DIV(CDIV)) u_stepper_image_props (.pclk(pclk),
		.presetn(presetn), .cycle(link.cycle), .out_image(link.out_image),
		.in_image(link.in_image));
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		ticks++;
		if (ticks == 5000) begin
			error_cnt++;
			test_done();
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask
	// control byte, then data word, then let exchanges settle
	task automatic wsync(input logic [7:0] c, input logic [15:0] d);
		apb(1'b1, stepper_image_pkg::APB_CMD, {24'h00_0000, c});
		apb(1'b1, stepper_image_pkg::APB_DATA_OUT, {16'h0000, d});
		repeat (3 * CDIV) @(posedge pclk);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_proc;
		apb(1'b1, stepper_image_pkg::APB_EXT_OUT, 32'h0000_a5c3);
		wsync(8'h01, 16'h1234);
		rdc(stepper_image_pkg::APB_DATA_IN, 32'h0000_5678);
		rdc(stepper_image_pkg::APB_EXT_IN, 32'h0000_5aa5);
		apb(1'b0, stepper_image_pkg::APB_STATUS, 32'h0000_0000);
		check({rd[7], rd[4], rd[0]}, 3'h3);
		check({link.in_image[2], link.in_image[1]}, 16'h5678);
		check(link.out_image[1], 8'h34);
		check(velocity_cmd, 16'h1234);
		check(ext_control, 16'ha5c3);
		apb(1'b1, stepper_image_pkg::APB_CTRL, 32'h0000_0001);
		@(posedge pclk);
		check({aligned_in[3], aligned_in[2], aligned_in[4]}, 24'h56_78a5);
		apb(1'b1, stepper_image_pkg::APB_CTRL, 32'h0000_0000);
	endtask
	task t_modes;
		mode <= stepper_image_pkg::MODE_VEL_RAMP;
		wsync(8'h01, 16'h123f);
		check(velocity_cmd, 16'h1230);
		wsync(8'h01, 16'h1230);
		check(velocity_cmd, 16'h1230);
		mode <= stepper_image_pkg::MODE_POS_TRACK;
		wsync(8'h01, 16'h0345);
		check(set_position, 16'h0345);
		check(velocity_valid, 1'b0);
	endtask
	task t_reg;
		wsync(8'hc2, 16'hbeef);
		wsync(8'hc3, 16'h1234);
		check(target_position, 32'h1234_beef);
		wsync(8'h81, 16'h0000);
		rdc(stepper_image_pkg::APB_DATA_IN, 32'h0000_1234);
		apb(1'b0, stepper_image_pkg::APB_STATUS, 32'h0000_0000);
		check({rd[7], rd[5:0]}, {1'b1, 6'h01});
		wsync(8'h80, 16'h0000);
		rdc(stepper_image_pkg::APB_DATA_IN, 32'h0000_5678);
	endtask
	task t_travel;
		mode <= stepper_image_pkg::MODE_TRAVEL;
		wsync(8'h01, 16'h0000);
		wsync(8'h05, 16'h0000);
		check(motion_start_bit, 1'b1);
		apb(1'b1, stepper_image_pkg::APB_DATA_OUT, 32'h0000_1000);
		repeat (3 * CDIV) @(posedge pclk);
		check(velocity_cmd, 16'h0000);
		wsync(8'h01, 16'h100f);
		check(motion_start_bit, 1'b0);
		check(velocity_cmd, 16'h1000);
		apb(1'b0, 8'h20, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001);
	endtask
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		presetn = 1'b0;
		mode = stepper_image_pkg::MODE_VEL_DIRECT;
		pos = 32'h1234_5678;
		idle = 1'b1;
		ext_st = 16'h5aa5;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_proc();
		t_modes();
		t_reg();
		t_travel();
		test_done();
	end
endmodule
